/* rtl/chb_consts.svh */
// Purpose : Named constants of the codec host bus port
// Assumes : Included by bare name from package and modules
// Notes   : Register indices are two-bit word addresses
`ifndef CHB_CONSTS_SVH
`define CHB_CONSTS_SVH

// ------------------------------------------------------------
// Direct register word addresses
// ------------------------------------------------------------
`define CHB_REG_IND_ADDR 2'h0
`define CHB_REG_IND_DATA 2'h1
`define CHB_REG_CDATA    2'h2
`define CHB_REG_INT      2'h3

// ------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------
`define CHB_INT_FLAG_BIT 0
`define CHB_INT_MASK_BIT 8
`define CHB_HALF_W       16
`define CHB_WORD_W       32
`define CHB_IND_AW       8
`define CHB_FIFO_AW      9

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CHB_MASK_RST     1'h0
`define CHB_ACK_N_RST    1'h1
`define CHB_INT_N_RST    1'h1

`endif

/* rtl/chb_pkg.sv */
// Purpose : Types shared by the codec host bus port files
// Assumes : chb_consts.svh supplies the widths
// Notes   : Host pins travel as one struct through the synchroniser
`include "chb_consts.svh"

package chb_pkg;

    // ------------------------------------------------------------
    // Access sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CHB_IDLE,
        CHB_WAIT,
        CHB_ACK
    } chb_fsm_e;

    // ------------------------------------------------------------
    // Host pin group, sampled as one unit
    // ------------------------------------------------------------
    typedef struct packed {
        logic                    cs_n;
        logic                    wr_n;
        logic                    rd_n;
        logic                    lo_n;
        logic                    hi_n;
        logic [1:0]              adr;
        logic [`CHB_WORD_W-1:0]  data;
    } chb_host_s;

endpackage

/* rtl/chb_sync.sv */
// Purpose : Two-flop synchroniser for a group of host pins
// Assumes : Pins idle high; resetting to that level avoids a false strobe
// Notes   : First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none

module chb_sync
    import chb_pkg::*;
#(
    parameter int W = 1
)(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Data
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta <= '1;
            q    <= '1;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

`default_nettype wire

/* rtl/chb_buf2.sv */
// Purpose : Two-entry buffer with valid and ready on both sides
// Assumes : Same clock on both sides
// Notes   : in_ready comes from a flop, so no combinational path back
`timescale 1ns/1ps
`default_nettype none

module chb_buf2
    import chb_pkg::*;
#(
    parameter int W = 32
)(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);

    typedef struct packed {
        logic         v0;
        logic         v1;
        logic [W-1:0] d0;
        logic [W-1:0] d1;
    } chb_buf_s;

    chb_buf_s s;
    chb_buf_s next_s;

    assign in_ready  = ~s.v1;
    assign out_valid = s.v0;
    assign out_data  = s.d0;

    always_comb
    begin
        next_s = s;
        if (s.v0 && out_ready)
        begin
            next_s.v0 = s.v1;
            next_s.d0 = s.d1;
            next_s.v1 = 1'b0;
        end
        if (in_valid && !s.v1)
        begin
            if (!next_s.v0)
            begin
                next_s.v0 = 1'b1;
                next_s.d0 = in_data;
            end
            else
            begin
                next_s.v1 = 1'b1;
                next_s.d1 = in_data;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s <= '0;
        else
            s <= next_s;
    end

endmodule

`default_nettype wire

/* rtl/chb_port.sv */
// Purpose : Asynchronous 16/32-bit host bus port with compressed-data FIFO
// Assumes : Host keeps address, enables and data stable until acknowledge
// Notes   : Strobes are sampled two cycles late; acknowledge reflects that
//
// Contract
// - Low enables low half, high enables high
// - FIFO advances only after upper half access
// - Indirect register steps on upper half access
// - Controls act only while chip select low
// - Data lines released while chip select high
// - Write data taken at strobe release
// - Read data driven while read strobe low
// - Every access completes with acknowledge low
// - Non-FIFO accesses get one wait cycle
// - Decode full FIFO stalls host writes
// - Encode empty FIFO stalls host reads
// - Service request follows FIFO thresholds
// - Status mirrors request; mask gates interrupt
// - No service condition clears request, flag
// - Two address bits select four registers
// - Encode request rises at nearly full
// - Decode request high until past nearly empty
`timescale 1ns/1ps
`default_nettype none

module chb_port
    import chb_pkg::*;
#(
    parameter int FIFO_AW = `CHB_FIFO_AW,
    parameter int IND_AW  = `CHB_IND_AW
)(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // Host pins
    input  wire logic                   cs_n,
    input  wire logic                   wr_n,
    input  wire logic                   rd_n,
    input  wire logic                   low_half_enable_n,
    input  wire logic                   high_half_enable_n,
    input  wire logic [1:0]             adr,
    input  wire logic [`CHB_WORD_W-1:0] data_in,
    output logic [`CHB_WORD_W-1:0]      data_out,
    output logic                        data_oe,
    output logic                        ack_n,
    output logic                        queue_service_request,
    output logic                        host_interrupt_n,
    // Core configuration and status
    input  wire logic                   encode_mode,
    input  wire logic                   soft_reset_bit,
    input  wire logic [FIFO_AW:0]       nearly_full_level,
    input  wire logic [FIFO_AW:0]       nearly_empty_level,
    output logic                        queue_service_flag,
    // Core indirect register port
    output logic [IND_AW-1:0]           ind_addr,
    output logic [`CHB_WORD_W-1:0]      ind_wdata,
    output logic                        ind_we,
    input  wire logic [`CHB_WORD_W-1:0] ind_rdata,
    // Core encode stream in
    input  wire logic                   enc_valid,
    input  wire logic [`CHB_WORD_W-1:0] enc_data,
    output logic                        enc_ready,
    // Core decode stream out
    output logic                        dec_valid,
    output logic [`CHB_WORD_W-1:0]      dec_data,
    input  wire logic                   dec_ready
);

    localparam int DEPTH = 1 << FIFO_AW;
    localparam logic [FIFO_AW:0] FULL_CNT = (FIFO_AW+1)'(DEPTH);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        chb_fsm_e                fsm;
        logic                    is_write;
        logic                    is_fifo;
        logic                    lo_en;
        logic                    hi_en;
        logic [1:0]              adr;
        logic [`CHB_WORD_W-1:0]  wdata;
        logic [`CHB_WORD_W-1:0]  rdata;
        logic [`CHB_WORD_W-1:0]  asm_word;
        logic                    oe;
        logic                    ack_n;
        logic [IND_AW-1:0]       ind_addr;
        logic [`CHB_WORD_W-1:0]  ind_wdata;
        logic                    ind_we;
        logic [FIFO_AW-1:0]      wr_ptr;
        logic [FIFO_AW-1:0]      rd_ptr;
        logic [FIFO_AW:0]        count;
        logic                    enc_ready;
        logic                    sr;
        logic                    flag;
        logic                    mask;
        logic                    int_n;
    } chb_state_s;

    chb_state_s st;
    chb_state_s next_st;

    logic [`CHB_WORD_W-1:0] mem [DEPTH];
    logic                   mem_we;
    logic [`CHB_WORD_W-1:0] mem_wdata;
    logic                   buf_ready;
    logic                   buf_push;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [`CHB_WORD_W-1:0] merge_half(
        input logic [`CHB_WORD_W-1:0] old_w,
        input logic [`CHB_WORD_W-1:0] new_w,
        input logic                   lo,
        input logic                   hi
    );
        logic [`CHB_WORD_W-1:0] r;
        r = old_w;
        if (lo)
            r[`CHB_HALF_W-1:0] = new_w[`CHB_HALF_W-1:0];
        if (hi)
            r[`CHB_WORD_W-1:`CHB_HALF_W] = new_w[`CHB_WORD_W-1:`CHB_HALF_W];
        return r;
    endfunction

    function automatic logic [FIFO_AW-1:0] ptr_inc(input logic [FIFO_AW-1:0] p);
        return p + FIFO_AW'(1);
    endfunction

    // ------------------------------------------------------------
    // Host pin synchronisation
    // ------------------------------------------------------------
    chb_host_s hin;
    chb_host_s sy;

    assign hin = '{cs_n: cs_n, wr_n: wr_n, rd_n: rd_n, lo_n: low_half_enable_n,
                   hi_n: high_half_enable_n, adr: adr, data: data_in};

    // Address and data are stable by the host's hold, so sampling them late is safe
    chb_sync #(.W($bits(chb_host_s))) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (hin),
        .q    (sy)
    );

    logic cs_act;
    logic wr_act;
    logic rd_act;
    logic strobe;
    logic fifo_full;
    logic fifo_empty;

    assign cs_act     = ~sy.cs_n;
    assign wr_act     = cs_act & ~sy.wr_n;
    assign rd_act     = cs_act & ~sy.rd_n;
    assign strobe     = wr_act | rd_act;
    assign fifo_full  = (st.count == FULL_CNT);
    assign fifo_empty = (st.count == '0);

    // ------------------------------------------------------------
    // Access sequencer and FIFO bookkeeping
    // ------------------------------------------------------------
    always_comb
    begin
        logic host_push;
        logic host_pop;
        logic core_push;
        logic core_pop;
        logic stall;
        logic req_fifo;
        host_push = 1'b0;
        host_pop  = 1'b0;
        core_push = 1'b0;
        core_pop  = 1'b0;
        stall     = 1'b0;
        req_fifo  = (sy.adr == `CHB_REG_CDATA);
        next_st   = st;
        next_st.ind_we = 1'b0;
        next_st.oe     = rd_act;
        mem_wdata      = enc_data;

        unique case (st.fsm)
            CHB_IDLE:
            begin
                next_st.ack_n = `CHB_ACK_N_RST;
                if (strobe)
                begin
                    // Stall before acknowledge; host keeps waiting for it
                    stall = req_fifo &&
                            ((wr_act && !encode_mode && fifo_full) ||
                             (rd_act && encode_mode && fifo_empty));
                    if (!stall)
                    begin
                        next_st.is_write = wr_act;
                        next_st.is_fifo  = req_fifo;
                        next_st.adr      = sy.adr;
                        next_st.lo_en    = ~sy.lo_n;
                        next_st.hi_en    = ~sy.hi_n;
                        next_st.wdata    = sy.data;
                        unique case (sy.adr)
                            `CHB_REG_IND_ADDR: next_st.rdata = `CHB_WORD_W'(st.ind_addr);
                            `CHB_REG_IND_DATA: next_st.rdata = ind_rdata;
                            `CHB_REG_CDATA:
                                next_st.rdata = encode_mode ? mem[st.rd_ptr] : '0;
                            `CHB_REG_INT:
                            begin
                                next_st.rdata = '0;
                                next_st.rdata[`CHB_INT_FLAG_BIT] = st.flag;
                                next_st.rdata[`CHB_INT_MASK_BIT] = st.mask;
                            end
                        endcase
                        next_st.fsm = req_fifo ? CHB_ACK : CHB_WAIT;
                        if (req_fifo)
                            next_st.ack_n = 1'b0;
                    end
                end
            end
            CHB_WAIT:
            begin
                next_st.ack_n = 1'b0;
                next_st.fsm   = CHB_ACK;
            end
            CHB_ACK:
            begin
                if (strobe)
                begin
                    next_st.ack_n = 1'b0;
                    next_st.wdata = sy.data;
                end
                else
                begin
                    // Release of the strobe is the write edge and the advance point
                    next_st.ack_n = `CHB_ACK_N_RST;
                    next_st.fsm   = CHB_IDLE;
                    if (st.is_write)
                    begin
                        unique case (st.adr)
                            `CHB_REG_IND_ADDR:
                                next_st.ind_addr = IND_AW'(merge_half(
                                    `CHB_WORD_W'(st.ind_addr), st.wdata, st.lo_en, st.hi_en));
                            `CHB_REG_IND_DATA:
                            begin
                                next_st.ind_wdata = merge_half(st.ind_wdata, st.wdata,
                                                               st.lo_en, st.hi_en);
                                next_st.ind_we    = 1'b1;
                            end
                            `CHB_REG_CDATA:
                                next_st.asm_word = merge_half(st.asm_word, st.wdata,
                                                              st.lo_en, st.hi_en);
                            `CHB_REG_INT:
                                if (st.lo_en)
                                    next_st.mask = st.wdata[`CHB_INT_MASK_BIT];
                        endcase
                    end
                    if (st.is_fifo && st.hi_en)
                    begin
                        host_push = st.is_write && !encode_mode;
                        host_pop  = !st.is_write && encode_mode;
                    end
                    if (st.adr == `CHB_REG_IND_DATA && st.hi_en)
                        next_st.ind_addr = next_st.ind_addr + IND_AW'(1);
                end
            end
            default:
            begin
                next_st.fsm   = CHB_IDLE;
                next_st.ack_n = `CHB_ACK_N_RST;
            end
        endcase

        core_push = encode_mode && enc_valid && st.enc_ready;
        core_pop  = !encode_mode && !fifo_empty && buf_ready;
        if (host_push)
            mem_wdata = merge_half(st.asm_word, st.wdata, st.lo_en, st.hi_en);
        mem_we   = host_push | core_push;
        buf_push = core_pop;

        if (mem_we)
            next_st.wr_ptr = ptr_inc(st.wr_ptr);
        if (host_pop | core_pop)
            next_st.rd_ptr = ptr_inc(st.rd_ptr);
        next_st.count = st.count + (FIFO_AW+1)'(mem_we) - (FIFO_AW+1)'(host_pop | core_pop);

        // Soft reset empties the FIFO; the request then shows the empty level
        if (soft_reset_bit)
        begin
            next_st.wr_ptr = '0;
            next_st.rd_ptr = '0;
            next_st.count  = '0;
            mem_we         = 1'b0;
            buf_push       = 1'b0;
        end

        next_st.enc_ready = encode_mode && (next_st.count != FULL_CNT) && !soft_reset_bit;
        next_st.sr = encode_mode ? (next_st.count >= nearly_full_level)
                                 : (next_st.count <= nearly_empty_level);
        next_st.flag  = next_st.sr;
        next_st.int_n = ~(st.flag & st.mask);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st       <= '0;
            st.fsm   <= CHB_IDLE;
            st.ack_n <= `CHB_ACK_N_RST;
            st.mask  <= `CHB_MASK_RST;
            st.int_n <= `CHB_INT_N_RST;
        end
        else
            st <= next_st;
    end

    // Storage has no reset; the read pointer and the count define what is valid
    always_ff @(posedge clk)
    begin
        if (mem_we)
            mem[st.wr_ptr] <= mem_wdata;
    end

    // ------------------------------------------------------------
    // Decode output buffer
    // ------------------------------------------------------------
    chb_buf2 #(.W(`CHB_WORD_W)) u_buf (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (buf_push),
        .in_data   (mem[st.rd_ptr]),
        .in_ready  (buf_ready),
        .out_valid (dec_valid),
        .out_data  (dec_data),
        .out_ready (dec_ready)
    );

    assign data_out              = st.rdata;
    assign data_oe               = st.oe;
    assign ack_n                 = st.ack_n;
    assign queue_service_request = st.sr;
    assign queue_service_flag    = st.flag;
    assign host_interrupt_n      = st.int_n;
    assign ind_addr              = st.ind_addr;
    assign ind_wdata             = st.ind_wdata;
    assign ind_we                = st.ind_we;
    assign enc_ready             = st.enc_ready;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_cs_high_float: assert property (sy.cs_n |=> !data_oe)
        else $error("data driven while chip select high");
    a_read_drive: assert property (rd_act |=> data_oe)
        else $error("read strobe low but data not driven");
    a_ack_wait_cyc: assert property ($fell(ack_n) && !st.is_fifo |-> $past(st.fsm) == CHB_WAIT)
        else $error("register access acknowledged without wait cycle");
    a_ack_held: assert property (st.fsm == CHB_ACK && strobe |=> !ack_n)
        else $error("acknowledge dropped while strobe held");
    a_full_stall: assert property (st.fsm == CHB_IDLE && wr_act && req_cd() && !encode_mode
                                   && fifo_full |=> ack_n)
        else $error("write acknowledged into full FIFO");
    a_empty_stall: assert property (st.fsm == CHB_IDLE && rd_act && req_cd() && encode_mode
                                    && fifo_empty |=> ack_n)
        else $error("read acknowledged from empty FIFO");
    a_lo_no_push: assert property (st.fsm == CHB_ACK && !strobe && st.is_fifo && !st.hi_en
                                   && !soft_reset_bit && !encode_mode
                                   |=> st.wr_ptr == $past(st.wr_ptr))
        else $error("FIFO advanced on lower half access");
    a_ind_step: assert property (st.fsm == CHB_ACK && !strobe && st.hi_en && !st.is_write
                                 && st.adr == `CHB_REG_IND_DATA
                                 |=> st.ind_addr == $past(st.ind_addr) + IND_AW'(1))
        else $error("indirect address did not step");
    a_wr_release: assert property (ind_we |-> $past(st.fsm) == CHB_ACK && !$past(strobe))
        else $error("indirect write not at strobe release");
    a_flag_mirror: assert property (queue_service_flag == queue_service_request)
        else $error("status flag differs from service request");
    a_int_gate: assert property (!host_interrupt_n |-> $past(st.flag && st.mask))
        else $error("interrupt without enabled flag");
    a_sr_reset: assert property ($past(soft_reset_bit) |-> queue_service_request == !encode_mode
                                 || $changed(encode_mode))
        else $error("service request wrong after soft reset");

    c_fifo_write: cover property (st.fsm == CHB_ACK && st.is_fifo && st.is_write ##1 !strobe);
    c_fifo_read: cover property (st.fsm == CHB_ACK && st.is_fifo && !st.is_write && st.hi_en);
    c_stall: cover property (st.fsm == CHB_IDLE && strobe && ack_n [*4]);
    c_int: cover property ($fell(host_interrupt_n));

    function automatic logic req_cd();
        return sy.adr == `CHB_REG_CDATA;
    endfunction

endmodule

`default_nettype wire

/* dv/chb_host_model.sv */
// Purpose: Host bus master driving the port's asynchronous pins
// Assumes: One access at a time, strobes launched at a clock edge
// Notes: Released data lines show the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module chb_host_model (
    // Clock and device answers
    input  wire logic        clk,
    input  wire logic        ack_n,
    input  wire logic        data_oe,
    input  wire logic [31:0] data_out,
    // Host pins
    output logic             cs_n,
    output logic             wr_n,
    output logic             rd_n,
    output logic             lo_n,
    output logic             hi_n,
    output logic [1:0]       adr,
    output logic [31:0]      data_in
);
    initial {cs_n, wr_n, rd_n, lo_n, hi_n, adr, data_in} = {5'h1f, 2'h0, 32'h0};
    // Hold all qualifiers until ack low, then release; a slow ack is waited out
    task automatic acc(input logic w, input logic [1:0] a, input logic [1:0] en,
                       input logic [31:0] wd, output logic [31:0] rd, output int n);
        n = 0;
        {cs_n, wr_n, rd_n, hi_n, lo_n, adr} <= {1'b0, ~w, w, ~en, a};
        data_in <= w ? wd : ~data_in;
        while (ack_n !== 1'b0)
        begin
            @(posedge clk);
            n++;
        end
        rd = (data_oe === 1'b1) ? data_out : 'x;
        {cs_n, wr_n, rd_n, hi_n, lo_n} <= 5'h1f;
        data_in <= ~data_in;
        while (ack_n !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
    endtask
    // Strobes with chip select high must not be answered
    task automatic ghost(output logic seen);
        seen = 1'b0;
        {wr_n, rd_n, lo_n, hi_n, adr} <= 6'h01;
        repeat (8)
        begin
            @(posedge clk);
            seen |= (ack_n !== 1'b1) | (data_oe !== 1'b0);
        end
        {wr_n, rd_n, lo_n, hi_n} <= 4'hf;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* dv/test_codec_host_bus_port.sv */
// Purpose: Self-checking bench of the codec host bus port
// Assumes: Small queue (FIFO_AW 3), thresholds tied
// Notes: Stall lengths are judged against the bench's own release delay
`timescale 1ns/1ps
`default_nettype none
`include "chb_consts.svh"
module test_codec_host_bus_port;
    logic        clk, nrst, enc_mode, srst, enc_valid, dec_ready, seen;
    logic        cs_n, wr_n, rd_n, lo_n, hi_n, ack_n, oe, srq, flag, int_n;
    logic        ind_we, enc_ready, dec_valid;
    logic [1:0]  adr;
    logic [7:0]  ind_addr;
    logic [31:0] din, dout, rdat, enc_data, dec_data, ind_wdata, w;
    logic [31:0] got[$];
    int          error_cnt, checks_done, n, n_max, we_cnt;
    chb_host_model host (.clk(clk), .ack_n(ack_n), .data_oe(oe), .data_out(dout),
        .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .lo_n(lo_n), .hi_n(hi_n), .adr(adr),
        .data_in(din));
    chb_port #(.FIFO_AW(3)) dut_u (.clk(clk), .nrst(nrst), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .low_half_enable_n(lo_n), .high_half_enable_n(hi_n), .adr(adr),
        .data_in(din), .data_out(dout), .data_oe(oe), .ack_n(ack_n),
        .queue_service_request(srq), .host_interrupt_n(int_n), .encode_mode(enc_mode),
        .soft_reset_bit(srst), .nearly_full_level(4'h4), .nearly_empty_level(4'h2),
        .queue_service_flag(flag), .ind_addr(ind_addr), .ind_wdata(ind_wdata),
        .ind_we(ind_we), .ind_rdata(32'h5a5a0f0f), .enc_valid(enc_valid),
        .enc_data(enc_data), .enc_ready(enc_ready), .dec_valid(dec_valid),
        .dec_data(dec_data), .dec_ready(dec_ready));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (dec_valid === 1'b1 && dec_ready === 1'b1)
            got.push_back(dec_data);
    always @(posedge clk)
        if (ind_we === 1'b1)
            we_cnt <= we_cnt + 1;
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic end_sim();
        $display("%0d checks, %0d mismatches", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // A full run needs about 1400 cycles
    initial
    begin
        #500us;
        error_cnt++;
        end_sim();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {nrst, enc_mode, srst, enc_valid, dec_ready, enc_data} = '0;
        {error_cnt, checks_done, n_max} = '0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        cmp(srq, 1, "decode empty request");
        cmp(flag, 1, "flag mirror");
        host.acc(1, `CHB_REG_INT, 2'b01, 32'h100, rdat, n);
        cmp(n > 8, 1, "register wait cycle");
        repeat (3) @(posedge clk);
        cmp(int_n, 0, "unmasked interrupt");
        host.acc(1, `CHB_REG_IND_ADDR, 2'b11, 32'h5, rdat, n);
        host.acc(1, `CHB_REG_IND_DATA, 2'b01, 32'h1111aaaa, rdat, n);
        cmp(ind_addr, 5, "no step on low half");
        host.acc(1, `CHB_REG_IND_DATA, 2'b10, 32'h2222bbbb, rdat, n);
        cmp(ind_wdata, 32'h2222aaaa, "halves merged");
        cmp(ind_addr, 6, "step on high half");
        host.ghost(seen);
        cmp(seen, 0, "deselected ignored");
        cmp(ind_addr, 6, "deselected no step");
        cmp(we_cnt, 2, "write pulses");
        host.acc(0, `CHB_REG_IND_DATA, 2'b11, 32'h0, rdat, n);
        cmp(rdat, 32'h5a5a0f0f, "indirect read");
        $display("register tests done");
        fork
            for (int i = 0; i < 14; i++)
            begin
                w = {16'h00a0 + 16'(i), 16'h0050 + 16'(i)};
                host.acc(1, `CHB_REG_CDATA, 2'b01, w, rdat, n);
                n_max = (n > n_max) ? n : n_max;
                host.acc(1, `CHB_REG_CDATA, 2'b10, w, rdat, n);
                if (i == 8)
                begin
                    cmp(srq, 0, "request low past level");
                    cmp(int_n, 1, "interrupt follows flag");
                end
            end
            begin
                repeat (900) @(posedge clk);
                dec_ready <= 1'b1;
            end
        join
        repeat (60) @(posedge clk);
        cmp(n_max > 200, 1, "full queue stalls write");
        cmp(got.size(), 14, "words out");
        for (int i = 0; i < 14 && i < got.size(); i++)
            cmp(got[i], {16'h00a0 + 16'(i), 16'h0050 + 16'(i)}, "word order");
        $display("decode tests done");
        enc_mode <= 1'b1;
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        cmp(srq, 0, "encode empty request");
        fork
            host.acc(0, `CHB_REG_CDATA, 2'b11, 32'h0, rdat, n);
            begin
                repeat (200) @(posedge clk);
                enc_valid <= 1'b1;
                for (int i = 0; i < 5; i++)
                begin
                    enc_data <= 32'hc0de0000 + 32'(i);
                    @(posedge clk);
                end
                enc_valid <= 1'b0;
            end
        join
        cmp(n > 150, 1, "empty queue stalls read");
        cmp(rdat, 32'hc0de0000, "head word");
        repeat (4) @(posedge clk);
        cmp(srq, 1, "request at nearly full");
        cmp(int_n, 0, "encode interrupt");
        host.acc(0, `CHB_REG_CDATA, 2'b01, 32'h0, rdat, n);
        w[15:0] = rdat[15:0];
        host.acc(0, `CHB_REG_CDATA, 2'b10, 32'h0, rdat, n);
        cmp({rdat[31:16], w[15:0]}, 32'hc0de0001, "16-bit read pair");
        host.acc(0, `CHB_REG_CDATA, 2'b11, 32'h0, rdat, n);
        cmp(rdat, 32'hc0de0002, "pop after high half");
        $display("encode tests done");
        end_sim();
    end
endmodule
`default_nettype wire
